// ---- rtl/usil_defs.vh ----
`ifndef USIL_DEFS_VH
`define USIL_DEFS_VH

// Register indices on the plain register port.
`define USIL_ADDR_W        3
`define USIL_A_DATA        3'h0
`define USIL_A_UCR         3'h1
`define USIL_A_BAUD_SELECT_REGISTER        3'h2
`define USIL_A_MCR         3'h3
`define USIL_A_USR         3'h4
`define USIL_A_MSR         3'h5

// Control register fields.
`define USIL_UCR_RXPEN     0
`define USIL_UCR_RXODD     1
`define USIL_UCR_TXPEN     2
`define USIL_UCR_TXODD     3
`define USIL_UCR_RST       4'h0

// Modem control register fields.
`define USIL_MCR_DTR       0
`define USIL_MCR_RTS       1
`define USIL_MCR_GIE       2
`define USIL_MCR_MIE       3
`define USIL_MCR_MODE_LO   4
`define USIL_MCR_MODE_HI   5
`define USIL_MCR_RXEN      6
`define USIL_MCR_RST       7'h00

// Operating modes.
`define USIL_MODE_NORMAL   2'h0
`define USIL_MODE_BREAK    2'h1
`define USIL_MODE_ECHO     2'h2
`define USIL_MODE_LOOP     2'h3

// Status register fields.
`define USIL_ST_DR         0
`define USIL_ST_OE         1
`define USIL_ST_PE         2
`define USIL_ST_FE         3
`define USIL_ST_BRK        4
`define USIL_ST_MS         5
`define USIL_ST_TC         6
`define USIL_ST_TX_BUFFER_EMPTY_FLAG       7
`define USIL_ST_RST        8'h40
`define USIL_ST_IRQ_MASK   8'h5e

// Modem status fields.
`define USIL_MS_CTS        0
`define USIL_MS_DSR        1

// Baud timing.
`define USIL_BAUD_SELECT_REGISTER_RST      8'h00
`define USIL_PRESCALE      8'h10
`define USIL_CNT_ONE       16'h0001
`define USIL_BITS_LAST     3'h7

`endif

// ---- rtl/usil_sync.v ----
`timescale 1ns/1ps
`include "usil_defs.vh"

module usil_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // Asynchronous inputs and their settled image
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            // A change is accepted only once stages two and three agree.
            always @(posedge clk_sys)
            begin
                if (rst)
                begin
                    stage1_reg[i] <= INIT[i];
                    stage2_reg[i] <= INIT[i];
                    stage3_reg[i] <= INIT[i];
                    level_out[i]  <= INIT[i];
                end
                else
                begin
                    stage1_reg[i] <= async_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                    stage3_reg[i] <= stage2_reg[i];
                    if (stage2_reg[i] == stage3_reg[i])
                        level_out[i] <= stage3_reg[i];
                end
            end
        end
    endgenerate

endmodule

// ---- rtl/usil_top.v ----
// Summary of operation
// R1: Transmitter shifts data bit zero out first in every character.
// R2: Transmit parity is configured separately from receive parity.
// R3: Buffer-empty pin and status flag both show holding buffer empty; the flag only sets when the buffer empties and is clear after reset.
// R4: Transmission complete sets only when holding and shift stages empty.
// R5: Modem enable and global enable bits mask the interrupt output.
// R6: Any change on DSR or CTS sets the modem edge detector.
// R7: Reading modem status clears its edge detector, not its bits.
// R8: Modem status bits always show the live modem pins.
// R9: Modem status bits read as inverse of the low-active pins.
// R10: The uart status edge detector fires only when a status bit rises.
// R11: Reading uart status clears its edge detector and all bits.
// R12: Buffer-empty and data-ready pins ignore status register reads.
// R13: Reset sets transmission complete with its edge already captured.
// R14: Software reads status before enabling interrupts to drop reset event.
// R15: During a status read new conditions wait until strobe end.
// R16: A set bit whose condition recurs during its read ends cleared.
// R17: Software reset writes control, baud select and modem control.
// R18: After software reset, read status and receive buffer first.
// R19: Baud divider gives standard rates from its reference clock.
// R20: Interrupt output stays low while global enable is false.
// R21: Modem event interrupts need both modem and global enables.
// R22: Buffer-empty and data-ready never drive the interrupt output.
// R23: Error flags update once per character during the stop bit.
// R24: Interrupt equals global enable and status or masked modem edge.
// R25: Deferred status updates happen in the cycle after the strobe.
`timescale 1ns/1ps
`include "usil_defs.vh"

module usil_top #(
    parameter       DATA_BITS = 8,
    parameter [7:0] PRESCALE  = `USIL_PRESCALE
) (
    // Clock and reset
    input  wire                    clk_sys,
    input  wire                    rst,
    // Register port
    input  wire [`USIL_ADDR_W-1:0] reg_addr,
    input  wire [7:0]              reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [7:0]              reg_rdata,
    // Serial line
    input  wire                    serial_in,
    output reg                     serial_out,
    // Modem lines
    input  wire                    cts_n,
    input  wire                    dsr_n,
    output reg                     rts_n,
    output reg                     dtr_n,
    // Request pins
    output reg                     tx_buffer_empty_pin,
    output reg                     rx_data_ready_pin,
    output reg                     irq_out
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_DATA  = 3'h2;
    localparam [2:0] ST_PAR   = 3'h3;
    localparam [2:0] ST_STOP  = 3'h4;

    // Registers written by software.
    reg  [3:0]  uart_control_register;
    reg  [7:0]  baud_select_register;
    reg  [6:0]  modem_control_register;

    // Transmit path.
    reg  [7:0]  tx_holding_buffer;
    reg         tx_hold_full_reg;
    reg  [7:0]  tx_shift_register;
    reg  [2:0]  tx_state_reg;
    reg  [2:0]  tx_bit_reg;
    reg  [15:0] tx_cnt_reg;
    reg         tx_line_reg;
    reg         tx_par_reg;
    reg         tx_complete_prev_reg;
    reg         tx_buffer_empty_flag_prev_reg;

    // Receive path.
    reg  [7:0]  rx_holding_buffer;
    reg         rx_full_reg;
    reg  [7:0]  rx_shift_reg;
    reg  [2:0]  rx_state_reg;
    reg  [2:0]  rx_bit_reg;
    reg  [15:0] rx_cnt_reg;
    reg         rx_par_reg;
    reg         rx_par_bad_reg;

    // Status, deferral and edge latches.
    reg  [7:0]  uart_status_register;
    reg  [7:0]  pend_reg;
    reg  [7:0]  snap_reg;
    reg         post_rd_reg;
    reg         post_clr_reg;
    reg         usr_edge_reg;
    reg         modem_edge_reg;
    reg  [1:0]  msr_prev_reg;

    wire [2:0]  pins_sync;
    wire [1:0]  modem_status_register;
    wire [1:0]  mode;
    wire        gie;
    wire        mie;
    wire [15:0] bit_len;
    wire [15:0] bit_last;
    wire [15:0] half_last;
    wire        rx_line;
    wire        tx_done;
    wire        tx_complete_flag;
    wire        tx_buffer_empty_flag;
    wire        rd_usr;
    wire        rd_msr;
    wire        rd_data;
    wire        wr_data;
    wire        modem_change_flag;
    wire        rx_stop_evt;
    wire        rx_stop_ok;
    wire        break_received_flag;
    wire        framing_error_flag;
    wire        parity_error_flag;
    wire [7:0]  cond;
    wire [7:0]  status_eff;
    wire [7:0]  status_next;

    usil_sync #(
        .WIDTH (3),
        .INIT  (3'h7)
    ) u_sync (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .async_in  ({dsr_n, cts_n, serial_in}),
        .level_out (pins_sync)
    );

    assign modem_status_register = ~pins_sync[2:1]; // R8 R9
    assign mode = modem_control_register[`USIL_MCR_MODE_HI:
                                         `USIL_MCR_MODE_LO];
    assign gie  = modem_control_register[`USIL_MCR_GIE];
    assign mie  = modem_control_register[`USIL_MCR_MIE];

    // Bit period is (select + 1) * prescale clocks of clk_sys. With a
    // reference clock of 2.4576MHz divided by the prescale the standard
    // rates come out exact.
    assign bit_len   = (baud_select_register + `USIL_CNT_ONE) * PRESCALE; // R19
    assign bit_last  = bit_len - `USIL_CNT_ONE;
    assign half_last = {1'b0, bit_len[15:1]} - `USIL_CNT_ONE;

    assign rx_line = (mode == `USIL_MODE_LOOP) ? tx_line_reg : pins_sync[0];

    assign rd_usr  = reg_rd && (reg_addr == `USIL_A_USR);
    assign rd_msr  = reg_rd && (reg_addr == `USIL_A_MSR);
    assign rd_data = reg_rd && (reg_addr == `USIL_A_DATA);
    assign wr_data = reg_wr && (reg_addr == `USIL_A_DATA);

    assign tx_done = (tx_state_reg == ST_IDLE);
    assign tx_buffer_empty_flag = ~tx_hold_full_reg; // R3
    assign tx_complete_flag = tx_buffer_empty_flag && tx_done; // R4
    assign modem_change_flag = |(modem_status_register ^ msr_prev_reg); // R6

    assign rx_stop_evt = (rx_state_reg == ST_STOP) && (rx_cnt_reg == 16'h0);
    assign rx_stop_ok  = rx_line;
    assign break_received_flag = rx_stop_evt && !rx_stop_ok &&
                                 (rx_shift_reg == 8'h00);
    assign framing_error_flag  = rx_stop_evt && !rx_stop_ok; // R23
    assign parity_error_flag   = rx_stop_evt && rx_par_bad_reg; // R23

    // Conditions that set status bits; buffer and completion flags set
    // on their rising levels only.
    assign cond[`USIL_ST_DR]   = rx_stop_evt;
    assign cond[`USIL_ST_OE]   = rx_stop_evt && rx_full_reg; // R23
    assign cond[`USIL_ST_PE]   = parity_error_flag;
    assign cond[`USIL_ST_FE]   = framing_error_flag;
    assign cond[`USIL_ST_BRK]  = break_received_flag;
    assign cond[`USIL_ST_MS]   = modem_change_flag;
    assign cond[`USIL_ST_TC]   = tx_complete_flag && !tx_complete_prev_reg;
    assign cond[`USIL_ST_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag && !tx_buffer_empty_flag_prev_reg;

    // One cycle after a status read the held conditions land; after a
    // status register read, bits that were set and recurred end cleared.
    assign status_eff = !post_rd_reg ? uart_status_register :
                        post_clr_reg ? (pend_reg & ~snap_reg) : // R11 R16
                        (uart_status_register ^ pend_reg); // R16 R25
    assign status_next = status_eff | cond;

    // Register writes.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            uart_control_register  <= `USIL_UCR_RST;
            baud_select_register   <= `USIL_BAUD_SELECT_REGISTER_RST;
            modem_control_register <= `USIL_MCR_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `USIL_A_UCR:
                    uart_control_register <= reg_wdata[3:0]; // R2
                `USIL_A_BAUD_SELECT_REGISTER:
                    baud_select_register <= reg_wdata;
                `USIL_A_MCR:
                    modem_control_register <= reg_wdata[6:0];
                default:
                    uart_control_register <= uart_control_register;
            endcase
        end
    end

    // Read data, valid in the cycle after the strobe.
    always @(posedge clk_sys)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `USIL_A_DATA: reg_rdata <= rx_holding_buffer;
                `USIL_A_UCR:  reg_rdata <= {4'h0, uart_control_register};
                `USIL_A_BAUD_SELECT_REGISTER: reg_rdata <= baud_select_register;
                `USIL_A_MCR:  reg_rdata <= {1'b0, modem_control_register};
                `USIL_A_USR:  reg_rdata <= status_eff;
                `USIL_A_MSR:  reg_rdata <= {6'h00, modem_status_register};
                default:      reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // Status register with read deferral.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            uart_status_register <= `USIL_ST_RST; // R13
            pend_reg     <= 8'h00;
            snap_reg     <= 8'h00;
            post_rd_reg  <= 1'b0;
            post_clr_reg <= 1'b0;
            msr_prev_reg <= 2'h0;
        end
        else
        begin
            msr_prev_reg <= modem_status_register;
            if (rd_usr || rd_msr)
            begin
                // Setting is inhibited while the read is in progress.
                uart_status_register <= status_eff; // R15
                pend_reg     <= cond; // R15
                snap_reg     <= status_eff;
                post_rd_reg  <= 1'b1;
                post_clr_reg <= rd_usr;
            end
            else
            begin
                uart_status_register <= status_next;
                pend_reg     <= 8'h00;
                post_rd_reg  <= 1'b0;
                post_clr_reg <= 1'b0;
            end
        end
    end

    // Edge latches and the interrupt output.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            usr_edge_reg   <= 1'b1; // R13
            modem_edge_reg <= 1'b0;
            irq_out        <= 1'b0;
        end
        else
        begin
            if (|(status_next & ~uart_status_register &
                  `USIL_ST_IRQ_MASK) && !(rd_usr || rd_msr))
                usr_edge_reg <= 1'b1; // R10 R22
            else if (rd_usr)
                usr_edge_reg <= 1'b0; // R11
            if (modem_change_flag)
                modem_edge_reg <= 1'b1; // R6
            else if (rd_msr)
                modem_edge_reg <= 1'b0; // R7
            irq_out <= gie && (usr_edge_reg ||
                               (modem_edge_reg && mie)); // R5 R20 R21 R24
        end
    end

    // Pins follow their own conditions, untouched by status reads.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            tx_buffer_empty_pin  <= 1'b1;
            rx_data_ready_pin    <= 1'b0;
            rts_n                <= 1'b1;
            dtr_n                <= 1'b1;
            tx_complete_prev_reg <= 1'b1;
            tx_buffer_empty_flag_prev_reg        <= 1'b1;
        end
        else
        begin
            tx_buffer_empty_pin  <= tx_buffer_empty_flag; // R3 R12
            rx_data_ready_pin    <= rx_full_reg; // R12
            rts_n <= ~modem_control_register[`USIL_MCR_RTS];
            dtr_n <= ~modem_control_register[`USIL_MCR_DTR];
            tx_complete_prev_reg <= tx_complete_flag;
            tx_buffer_empty_flag_prev_reg        <= tx_buffer_empty_flag;
        end
    end

    // Transmitter; CTS high keeps a new character from starting.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            tx_holding_buffer <= 8'h00;
            tx_hold_full_reg  <= 1'b0;
            tx_shift_register <= 8'h00;
            tx_state_reg      <= ST_IDLE;
            tx_bit_reg        <= 3'h0;
            tx_cnt_reg        <= 16'h0;
            tx_line_reg       <= 1'b1;
            tx_par_reg        <= 1'b0;
        end
        else
        begin
            if (wr_data)
            begin
                tx_holding_buffer <= reg_wdata;
                tx_hold_full_reg  <= 1'b1;
            end
            case (tx_state_reg)
                ST_IDLE:
                begin
                    tx_line_reg <= 1'b1;
                    if (tx_hold_full_reg && !pins_sync[1] &&
                        mode != `USIL_MODE_ECHO && !wr_data)
                    begin
                        tx_shift_register <= tx_holding_buffer;
                        tx_hold_full_reg  <= 1'b0;
                        tx_par_reg <= uart_control_register[`USIL_UCR_TXODD];
                        tx_line_reg  <= 1'b0;
                        tx_cnt_reg   <= bit_last;
                        tx_state_reg <= ST_START;
                    end
                end
                default:
                begin
                    if (tx_cnt_reg != 16'h0)
                        tx_cnt_reg <= tx_cnt_reg - `USIL_CNT_ONE;
                    else
                    begin
                        tx_cnt_reg <= bit_last;
                        case (tx_state_reg)
                            ST_START, ST_DATA:
                            begin
                                if (tx_state_reg == ST_START)
                                    tx_bit_reg <= 3'h0;
                                else
                                    tx_bit_reg <= tx_bit_reg + 3'h1;
                                if (tx_state_reg == ST_DATA &&
                                    tx_bit_reg == `USIL_BITS_LAST)
                                begin
                                    if (uart_control_register[
                                            `USIL_UCR_TXPEN])
                                    begin
                                        tx_line_reg  <= tx_par_reg;
                                        tx_state_reg <= ST_PAR;
                                    end
                                    else
                                    begin
                                        tx_line_reg  <= 1'b1;
                                        tx_state_reg <= ST_STOP;
                                    end
                                end
                                else
                                begin
                                    tx_line_reg <= tx_shift_register[0]; // R1
                                    tx_par_reg  <= tx_par_reg ^
                                                   tx_shift_register[0];
                                    tx_shift_register <=
                                        {1'b0, tx_shift_register[7:1]}; // R1
                                    tx_state_reg <= ST_DATA;
                                end
                            end
                            ST_PAR:
                            begin
                                tx_line_reg  <= 1'b1;
                                tx_state_reg <= ST_STOP;
                            end
                            default:
                                tx_state_reg <= ST_IDLE; // R4
                        endcase
                    end
                end
            endcase
        end
    end

    // Line output per operating mode.
    always @(posedge clk_sys)
    begin
        if (rst)
            serial_out <= 1'b1;
        else
        begin
            case (mode)
                `USIL_MODE_BREAK: serial_out <= 1'b0;
                `USIL_MODE_ECHO:  serial_out <= pins_sync[0];
                `USIL_MODE_LOOP:  serial_out <= 1'b1;
                default:          serial_out <= tx_line_reg;
            endcase
        end
    end

    // Receiver: samples mid-bit, loads the holding buffer at the stop bit.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_holding_buffer <= 8'h00;
            rx_full_reg    <= 1'b0;
            rx_shift_reg   <= 8'h00;
            rx_state_reg   <= ST_IDLE;
            rx_bit_reg     <= 3'h0;
            rx_cnt_reg     <= 16'h0;
            rx_par_reg     <= 1'b0;
            rx_par_bad_reg <= 1'b0;
        end
        else
        begin
            if (rd_data)
                rx_full_reg <= 1'b0;
            if (rx_state_reg == ST_IDLE)
            begin
                if (!rx_line && modem_control_register[`USIL_MCR_RXEN])
                begin
                    rx_cnt_reg   <= half_last;
                    rx_state_reg <= ST_START;
                end
            end
            else if (rx_cnt_reg != 16'h0)
                rx_cnt_reg <= rx_cnt_reg - `USIL_CNT_ONE;
            else
            begin
                rx_cnt_reg <= bit_last;
                case (rx_state_reg)
                    ST_START:
                    begin
                        rx_bit_reg   <= 3'h0;
                        rx_par_reg   <= uart_control_register[`USIL_UCR_RXODD];
                        rx_state_reg <= rx_line ? ST_IDLE : ST_DATA;
                    end
                    ST_DATA:
                    begin
                        rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                        rx_par_reg   <= rx_par_reg ^ rx_line;
                        rx_bit_reg   <= rx_bit_reg + 3'h1;
                        rx_par_bad_reg <= 1'b0;
                        if (rx_bit_reg == `USIL_BITS_LAST)
                            rx_state_reg <=
                                uart_control_register[`USIL_UCR_RXPEN] ?
                                ST_PAR : ST_STOP;
                    end
                    ST_PAR:
                    begin
                        rx_par_bad_reg <= rx_par_reg ^ rx_line;
                        rx_state_reg   <= ST_STOP;
                    end
                    default:
                    begin
                        rx_holding_buffer <= rx_shift_reg;
                        rx_full_reg  <= 1'b1;
                        rx_state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ---- test/usil_monitor.sv ----
`timescale 1ns/1ps
module usil_monitor (
    // Clock, reset and register port
    input wire       clk_sys, rst, reg_wr, reg_rd,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata, reg_rdata,
    // Pins
    input wire       cts_n, dsr_n, rts_n, dtr_n, irq_out,
    input wire       tx_buffer_empty_pin, rx_data_ready_pin
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    reg [7:0] mcr_reg;
    reg [1:0] pin_reg;
    reg [2:0] quiet_reg;
    // Mirrors modem control writes; counts quiet cycles on the modem pins.
    always @(posedge clk_sys)
    begin
        pin_reg <= {dsr_n, cts_n};
        if (rst)
            mcr_reg <= 8'h00;
        else if (reg_wr && reg_addr == 3'h3)
            mcr_reg <= reg_wdata;
        if (rst || pin_reg != {dsr_n, cts_n})
            quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7)
            quiet_reg <= quiet_reg + 3'h1;
    end
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_rdata_unmapped: assert property (
        $past(reg_rd && reg_addr > 3'h5) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_gie_low: assert property (
        !mcr_reg[2] && !$past(mcr_reg[2]) |-> !irq_out)
        else $error("interrupt without global enable");
    a_irq_rise_gated: assert property (
        $rose(irq_out) |-> mcr_reg[2] && $past(mcr_reg[2]))
        else $error("interrupt rose while disabled");
    a_pins_follow: assert property (mcr_reg == $past(mcr_reg)
        |-> rts_n == !mcr_reg[1] && dtr_n == !mcr_reg[0])
        else $error("modem outputs differ from control");
    a_pins_hold: assert property (
        reg_rd && reg_addr == 3'h4 && !reg_wr && !$past(reg_wr)
        |=> tx_buffer_empty_pin >= $past(tx_buffer_empty_pin)
        && rx_data_ready_pin >= $past(rx_data_ready_pin))
        else $error("request pin dropped by status read");
    a_modem_irq: assert property (
        mcr_reg[3:2] == 2'h3 && $past(mcr_reg[3:2]) == 2'h3
        && $changed(cts_n) |-> ##[1:10] irq_out)
        else $error("modem change gave no interrupt");
    a_msr_live: assert property (
        $past(reg_rd && reg_addr == 3'h5) && quiet_reg == 3'h7
        |-> reg_rdata[1:0] == ~{dsr_n, cts_n})
        else $error("modem status not live inverse");
endmodule
bind usil_top usil_monitor u_mon (.*);

// ---- test/usil_modem.sv ----
`timescale 1ns/1ps
module usil_modem (
    // Clock and wishes of the test
    input  wire clk_sys,
    input  wire want_cts,
    input  wire want_dsr,
    // Line side
    input  wire serial_out,
    output reg  cts_n = 1'b1,
    output reg  dsr_n = 1'b1,
    output wire serial_in
);
    // A loop plug joins the transmit line back to the receive line.
    assign serial_in = serial_out;
    always @(posedge clk_sys)
    begin
        cts_n <= ~want_cts;
        dsr_n <= ~want_dsr;
    end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    localparam P = 2;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg  [2:0]  reg_addr = 3'h0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         want_cts = 1'b0;
    reg         want_dsr = 1'b0;
    wire [7:0]  reg_rdata;
    wire        serial_in, serial_out, cts_n, dsr_n, irq_out, tbe, rdy;
    integer     n_fail = 0;
    integer     tests_run = 0;
    integer     i;
    reg  [7:0]  got;
    // Rows: write flag and address, write data, expected read data.
    reg  [19:0] rows [0:6];
    usil_top #(.PRESCALE(8'h02)) uut (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in(serial_in),
        .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
        .rts_n(), .dtr_n(), .tx_buffer_empty_pin(tbe),
        .rx_data_ready_pin(rdy), .irq_out(irq_out));
    usil_modem far (.clk_sys(clk_sys), .want_cts(want_cts),
        .want_dsr(want_dsr), .serial_out(serial_out), .cts_n(cts_n),
        .dsr_n(dsr_n), .serial_in(serial_in));
    always #20 clk_sys = ~clk_sys;
    task ticks(input integer n);
    begin
        repeat (n) @(posedge clk_sys);
        #1;
    end
    endtask
    task bus(input w, input [2:0] a, input [7:0] d);
    begin
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    end
    endtask
    task check(input [63:0] what, input [7:0] exp, input [7:0] seen);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task chk_irq(input [7:0] e);
    begin
        ticks(3);
        check("irq", e, {7'h00, irq_out});
    end
    endtask
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    initial
    begin
        #400000;
        n_fail = n_fail + 1;
        stop_test;
    end
    initial
    begin
        rows[0] = 20'h90000;
        rows[1] = 20'ha0000;
        rows[2] = 20'hb0000;
        rows[3] = 20'h40040;
        rows[4] = 20'h40000;
        rows[5] = 20'h50000;
        rows[6] = 20'h60000;
        ticks(5);
        rst <= 1'b0;
        ticks(6);
        for (i = 0; i < 7; i = i + 1)
        begin
            bus(rows[i][19], rows[i][18:16], rows[i][15:8]);
            if (!rows[i][19])
                check("row", rows[i][7:0], got);
        end
        bus(1'b1, 3'h3, 8'h04);
        chk_irq(8'h00);
        rst <= 1'b1;
        ticks(2);
        rst <= 1'b0;
        ticks(6);
        bus(1'b1, 3'h3, 8'h04);
        chk_irq(8'h01);
        bus(1'b0, 3'h4, 8'h00);
        chk_irq(8'h00);
        bus(1'b1, 3'h3, 8'h0c);
        want_cts <= 1'b1;
        ticks(4);
        bus(1'b0, 3'h4, 8'h00);
        check("usr", 8'h00, got);
        chk_irq(8'h01);
        bus(1'b0, 3'h4, 8'h00);
        check("usr", 8'h20, got);
        chk_irq(8'h01);
        bus(1'b0, 3'h5, 8'h00);
        check("msr", 8'h01, got);
        chk_irq(8'h00);
        bus(1'b1, 3'h3, 8'h04);
        want_dsr <= 1'b1;
        ticks(9);
        chk_irq(8'h00);
        bus(1'b0, 3'h5, 8'h00);
        check("msr", 8'h03, got);
        bus(1'b1, 3'h3, 8'h08);
        want_cts <= 1'b0;
        ticks(9);
        chk_irq(8'h00);
        bus(1'b1, 3'h3, 8'h0c);
        chk_irq(8'h01);
        bus(1'b1, 3'h1, 8'h0d);
        bus(1'b1, 3'h3, 8'h43);
        want_cts <= 1'b1;
        ticks(12);
        bus(1'b0, 3'h4, 8'h00);
        bus(1'b1, 3'h0, 8'h35);
        ticks(1);
        check("tbe", 8'h00, {7'h00, tbe});
        for (i = 0; i < 100 && serial_out; i = i + 1)
            ticks(1);
        for (i = 0; i < 8; i = i + 1)
        begin
            ticks(P);
            got[i] = serial_out;
        end
        check("txbits", 8'h35, got);
        ticks(40);
        bus(1'b0, 3'h4, 8'h00);
        check("usr", 8'hc5, got);
        check("pins", 8'h03, {6'h00, tbe, rdy});
        bus(1'b0, 3'h0, 8'h00);
        check("rx", 8'h35, got);
        stop_test;
    end
endmodule
